// [gec_map.svh]
`ifndef GEC_MAP_SVH
`define GEC_MAP_SVH

// register byte offsets
`define GEC_CTRL_OFF      12'h000
`define GEC_STATUS_OFF    12'h004
`define GEC_IRQ_STAT_OFF  12'h030
`define GEC_IRQ_MASK_OFF  12'h034

// engine_control_reg fields
`define GEC_SEQ_HI        31
`define GEC_SEQ_LO        16
`define GEC_COMP_BIT      4
`define GEC_SEQC_BIT      3
`define GEC_ABORT_BIT     2
`define GEC_RESTART_BIT   1
`define GEC_ENABLE_BIT    0

// reset values
`define GEC_SEQ_RST       16'h0000
`define GEC_ERR_RST       4'h0
`define GEC_IRQ_RST       3'h0

// error reasons
`define GEC_ERR_BAD_COMP   4'h2
`define GEC_ERR_BAD_SEQ    4'h3
`define GEC_ERR_ABORT_IDLE 4'he
`define GEC_ERR_ABORT_EXEC 4'hf

// interrupt status bits
`define GEC_IRQ_DONE      0
`define GEC_IRQ_ERR       1
`define GEC_IRQ_ABORT     2

// axi responses
`define GEC_RESP_OKAY     2'b00
`define GEC_RESP_SLVERR   2'b10

`endif

// [gec_pkg.sv]
package gec_pkg;
	typedef enum logic [1:0] {
		GEC_IDLE  = 2'b00,
		GEC_EXEC  = 2'b01,
		GEC_STALL = 2'b10
	} gec_state_t;
endpackage

// [gec_ctrl.sv]
// Notes on behaviour
// (RULE_01) initial sequence loads on restart or enable rise
// (RULE_02) expected sequence used only while check enabled
// (RULE_03) bit 4 enables ones-complement command check
// (RULE_04) bit 3 enables sequence number check
// (RULE_05) abort ends command and stalls endpoint
// (RULE_06) software follows abort with restart
// (RULE_07) software never writes abort with restart
// (RULE_08) restart clears stall, counters and holding state
// (RULE_09) restart also flushes pixel retriever and converter
// (RULE_10) software restarts only while command state stalled
// (RULE_11) enable bit lets engine fetch commands
// (RULE_12) disable finishes current command then stops
// (RULE_13) software re-enables only when all idle
// (RULE_14) next sequence number increments per completed command
// (RULE_15) abort reason 14 when idle, 15 executing
// (RULE_16) restart clears error reason and type
// (RULE_17) abort and restart bits self-clear
// (RULE_18) reserved bits 15:5 read zero
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gec_map.svh"

module gec_ctrl
	import gec_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        cmd_start,
	input  wire logic [15:0] cmd_seq,
	input  wire logic [15:0] cmd_value,
	input  wire logic [15:0] cmd_value_n,
	input  wire logic        cmd_done,
	input  wire logic        cmd_err,
	input  wire logic [3:0]  cmd_err_reason,
	input  wire logic [3:0]  cmd_err_type,
	input  wire logic        read_master_busy,
	input  wire logic        write_master_busy,
	output logic             fetch_enable,
	output logic             engine_abort,
	output logic             engine_restart,
	output logic             flush_pixels,
	output logic             endpoint_stall,
	output logic [15:0]      next_sequence_number,
	output logic             irq
);

	logic        awready_q, aw_held_q, wready_q, w_held_q;
	logic [11:0] awaddr_q;
	logic [31:0] wdata_q;
	logic [3:0]  wstrb_q;
	logic        bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic [15:0] init_seq_q, next_seq_q;
	logic        enable_q, seqc_q, comp_q, fetch_q;
	logic        abort_q, restart_q, flush_q, stall_q, irq_q;
	logic [3:0]  err_reason_q, err_type_q;
	logic        rd_busy_q, wr_busy_q;
	logic [2:0]  irq_stat_q, irq_mask_q, irq_set, irq_stat_d;
	gec_state_t  state_q, state_d;

	logic        aw_take, w_take, b_take, ar_take, r_take, do_write;
	logic        wr_ctrl, wr_istat, wr_imask, map_ok;
	logic        wr_abort, wr_restart, en_rise;
	logic        comp_bad, seq_bad, start_ok;
	logic [15:0] init_seq_d;
	logic [31:0] rd_val;
	logic        rd_ok;

	assign aw_take  = s_axi_awvalid & awready_q;
	assign w_take   = s_axi_wvalid & wready_q;
	assign b_take   = bvalid_q & s_axi_bready;
	assign ar_take  = s_axi_arvalid & arready_q;
	assign r_take   = rvalid_q & s_axi_rready;
	assign do_write = aw_held_q & w_held_q & ~bvalid_q;

	// write decode, word aligned
	always_comb begin
		wr_ctrl  = 1'b0;
		wr_istat = 1'b0;
		wr_imask = 1'b0;
		map_ok   = 1'b1;
		if ({awaddr_q[11:2], 2'b00} == `GEC_CTRL_OFF) begin
			wr_ctrl = do_write;
		end else if ({awaddr_q[11:2], 2'b00} == `GEC_STATUS_OFF) begin
			map_ok = 1'b1;
		end else if ({awaddr_q[11:2], 2'b00} == `GEC_IRQ_STAT_OFF) begin
			wr_istat = do_write;
		end else if ({awaddr_q[11:2], 2'b00} == `GEC_IRQ_MASK_OFF) begin
			wr_imask = do_write;
		end else begin
			map_ok = 1'b0;
		end
	end

	assign wr_abort   = wr_ctrl & wstrb_q[0] & wdata_q[`GEC_ABORT_BIT];
	assign wr_restart = wr_ctrl & wstrb_q[0] & wdata_q[`GEC_RESTART_BIT];
	assign en_rise    = wr_ctrl & wstrb_q[0] & wdata_q[`GEC_ENABLE_BIT]
	                    & ~enable_q;

	always_comb begin
		init_seq_d = init_seq_q;
		if (wr_ctrl && wstrb_q[2]) begin
			init_seq_d[7:0] = wdata_q[23:16];
		end
		if (wr_ctrl && wstrb_q[3]) begin
			init_seq_d[15:8] = wdata_q[31:24];
		end
	end

	// start checks
	assign comp_bad = comp_q & (cmd_value != ~cmd_value_n); // RULE_03
	assign seq_bad  = seqc_q & (cmd_seq != next_seq_q); // RULE_02 RULE_04
	assign start_ok = cmd_start & fetch_q;

	// axi write channels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b0;
			awaddr_q  <= 12'h000;
		end else if (aw_take) begin
			awready_q <= 1'b0;
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (b_take) begin
			awready_q <= 1'b1;
			aw_held_q <= 1'b0;
		end else if (!aw_held_q) begin
			awready_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b0;
			wdata_q  <= 32'h0000_0000;
			wstrb_q  <= 4'h0;
		end else if (w_take) begin
			wready_q <= 1'b0;
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb_q  <= s_axi_wstrb;
		end else if (b_take) begin
			wready_q <= 1'b1;
			w_held_q <= 1'b0;
		end else if (!w_held_q) begin
			wready_q <= 1'b1;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			bvalid_q <= 1'b0;
			bresp_q  <= `GEC_RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q  <= map_ok ? `GEC_RESP_OKAY : `GEC_RESP_SLVERR;
		end else if (b_take) begin
			bvalid_q <= 1'b0;
		end
	end

	// read mux
	always_comb begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		if ({s_axi_araddr[11:2], 2'b00} == `GEC_CTRL_OFF) begin
			rd_val = {init_seq_q, 11'h000, comp_q, seqc_q,
			          2'b00, enable_q}; // RULE_17 RULE_18
		end else if ({s_axi_araddr[11:2], 2'b00} == `GEC_STATUS_OFF) begin
			rd_val = {next_seq_q, 4'h0, err_type_q, err_reason_q,
			          rd_busy_q, wr_busy_q, state_q};
		end else if ({s_axi_araddr[11:2], 2'b00} == `GEC_IRQ_STAT_OFF) begin
			rd_val = {29'h0000_0000, irq_stat_q};
		end else if ({s_axi_araddr[11:2], 2'b00} == `GEC_IRQ_MASK_OFF) begin
			rd_val = {29'h0000_0000, irq_mask_q};
		end else begin
			rd_ok = 1'b0;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= `GEC_RESP_OKAY;
		end else if (ar_take) begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_val;
			rresp_q   <= rd_ok ? `GEC_RESP_OKAY : `GEC_RESP_SLVERR;
		end else if (r_take) begin
			arready_q <= 1'b1;
			rvalid_q  <= 1'b0;
		end else if (!rvalid_q) begin
			arready_q <= 1'b1;
		end
	end

	// control fields
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			init_seq_q <= `GEC_SEQ_RST;
			enable_q   <= 1'b0; // RULE_11
			seqc_q     <= 1'b0;
			comp_q     <= 1'b0;
		end else begin
			init_seq_q <= init_seq_d; // RULE_01
			if (wr_ctrl && wstrb_q[0]) begin
				enable_q <= wdata_q[`GEC_ENABLE_BIT];
				seqc_q   <= wdata_q[`GEC_SEQC_BIT]; // RULE_04
				comp_q   <= wdata_q[`GEC_COMP_BIT]; // RULE_03
			end
		end
	end

	// self-clearing strobes
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			abort_q   <= 1'b0;
			restart_q <= 1'b0;
			flush_q   <= 1'b0;
		end else begin
			abort_q   <= wr_abort; // RULE_05 RULE_17
			restart_q <= wr_restart; // RULE_08 RULE_17
			flush_q   <= wr_restart; // RULE_09
		end
	end

	// command state
	always_comb begin
		state_d = state_q;
		case (state_q)
			GEC_IDLE: begin
				if (wr_abort) begin
					state_d = GEC_STALL; // RULE_05
				end else if (start_ok) begin
					state_d = (comp_bad | seq_bad) ? GEC_STALL : GEC_EXEC;
				end
			end
			GEC_EXEC: begin
				if (wr_abort || cmd_err) begin
					state_d = GEC_STALL; // RULE_05
				end else if (cmd_done) begin
					state_d = GEC_IDLE; // RULE_12
				end
			end
			GEC_STALL: begin
				if (wr_restart) begin
					state_d = GEC_IDLE; // RULE_08
				end
			end
			default: state_d = GEC_IDLE;
		endcase
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			state_q <= GEC_IDLE;
			stall_q <= 1'b0;
			fetch_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stall_q <= (state_d == GEC_STALL);
			fetch_q <= enable_q & (state_d != GEC_STALL); // RULE_11 RULE_12
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			next_seq_q <= `GEC_SEQ_RST;
		end else if (wr_restart || en_rise) begin
			next_seq_q <= init_seq_d; // RULE_01
		end else if (state_q == GEC_EXEC && cmd_done && !cmd_err
		             && !wr_abort) begin
			next_seq_q <= next_seq_q + 16'h0001; // RULE_14
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			err_reason_q <= `GEC_ERR_RST;
			err_type_q   <= `GEC_ERR_RST;
		end else if (wr_restart) begin
			err_reason_q <= `GEC_ERR_RST; // RULE_16
			err_type_q   <= `GEC_ERR_RST;
		end else if (wr_abort && state_q == GEC_IDLE) begin
			err_reason_q <= `GEC_ERR_ABORT_IDLE; // RULE_15
		end else if (wr_abort && state_q == GEC_EXEC) begin
			err_reason_q <= `GEC_ERR_ABORT_EXEC; // RULE_15
		end else if (state_q == GEC_IDLE && start_ok && comp_bad) begin
			err_reason_q <= `GEC_ERR_BAD_COMP;
		end else if (state_q == GEC_IDLE && start_ok && seq_bad) begin
			err_reason_q <= `GEC_ERR_BAD_SEQ;
		end else if (state_q == GEC_EXEC && cmd_err) begin
			err_reason_q <= cmd_err_reason;
			err_type_q   <= cmd_err_type;
		end
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rd_busy_q <= 1'b0;
			wr_busy_q <= 1'b0;
		end else begin
			rd_busy_q <= read_master_busy;
			wr_busy_q <= write_master_busy;
		end
	end

	// interrupts, set beats clear
	always_comb begin
		irq_set = `GEC_IRQ_RST;
		irq_set[`GEC_IRQ_DONE]  = state_q == GEC_EXEC & state_d == GEC_IDLE;
		irq_set[`GEC_IRQ_ERR]   = state_q != GEC_STALL
		                          & state_d == GEC_STALL & ~wr_abort;
		irq_set[`GEC_IRQ_ABORT] = wr_abort;
		irq_stat_d = irq_stat_q;
		if (wr_istat && wstrb_q[0]) begin
			irq_stat_d = irq_stat_q & ~wdata_q[2:0];
		end
		irq_stat_d = irq_stat_d | irq_set;
	end

	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_stat_q <= `GEC_IRQ_RST;
			irq_mask_q <= `GEC_IRQ_RST;
			irq_q      <= 1'b0;
		end else begin
			irq_stat_q <= irq_stat_d;
			if (wr_imask && wstrb_q[0]) begin
				irq_mask_q <= wdata_q[2:0];
			end
			irq_q <= |(irq_stat_d & (wr_imask && wstrb_q[0]
			          ? wdata_q[2:0] : irq_mask_q));
		end
	end

	assign s_axi_awready        = awready_q;
	assign s_axi_wready         = wready_q;
	assign s_axi_bvalid         = bvalid_q;
	assign s_axi_bresp          = bresp_q;
	assign s_axi_arready        = arready_q;
	assign s_axi_rvalid         = rvalid_q;
	assign s_axi_rdata          = rdata_q;
	assign s_axi_rresp          = rresp_q;
	assign fetch_enable         = fetch_q;
	assign engine_abort         = abort_q;
	assign engine_restart       = restart_q;
	assign flush_pixels         = flush_q;
	assign endpoint_stall       = stall_q;
	assign next_sequence_number = next_seq_q;
	assign irq                  = irq_q;

	abort_self_clear_a: assert property (@(posedge mclk) disable iff (rst) // RULE_17
		abort_q |=> !abort_q)
		else $error("abort strobe did not self-clear");

	restart_clears_err_a: assert property (@(posedge mclk) disable iff (rst) // RULE_16
		restart_q |-> err_reason_q == 4'h0 && err_type_q == 4'h0)
		else $error("restart left error fields set");

	restart_flush_a: assert property (@(posedge mclk) disable iff (rst) // RULE_09
		restart_q |-> flush_q && state_q == GEC_IDLE && !stall_q)
		else $error("restart did not flush and recover");

	restart_seq_load_a: assert property (@(posedge mclk) disable iff (rst) // RULE_01
		restart_q |-> next_seq_q == init_seq_q)
		else $error("restart did not load sequence number");

	seq_increment_a: assert property (@(posedge mclk) disable iff (rst) // RULE_14
		state_q == GEC_EXEC && cmd_done && !cmd_err && !wr_abort
		&& !wr_restart && !en_rise
		|=> next_seq_q == $past(next_seq_q) + 16'h0001)
		else $error("sequence number did not advance");

	abort_idle_reason_a: assert property (@(posedge mclk) disable iff (rst) // RULE_15
		state_q == GEC_IDLE && wr_abort && !wr_restart
		|=> err_reason_q == 4'he && state_q == GEC_STALL ##1 stall_q)
		else $error("idle abort reason or stall wrong");

	abort_exec_reason_a: assert property (@(posedge mclk) disable iff (rst) // RULE_15
		state_q == GEC_EXEC && wr_abort && !wr_restart
		|=> err_reason_q == 4'hf && abort_q)
		else $error("executing abort reason wrong");

	disabled_no_fetch_a: assert property (@(posedge mclk) disable iff (rst) // RULE_11
		!enable_q && !en_rise |=> !fetch_q)
		else $error("fetch enabled while engine disabled");

	no_check_start_a: assert property (@(posedge mclk) disable iff (rst) // RULE_02
		state_q == GEC_IDLE && start_ok && !seqc_q && !comp_q && !wr_abort
		|=> state_q == GEC_EXEC)
		else $error("unchecked command not started");

	comp_fail_a: assert property (@(posedge mclk) disable iff (rst) // RULE_03
		state_q == GEC_IDLE && start_ok && comp_bad && !wr_abort
		|=> state_q == GEC_STALL && err_reason_q == 4'h2)
		else $error("complement failure not flagged");

	disable_finish_a: assert property (@(posedge mclk) disable iff (rst) // RULE_12
		state_q == GEC_EXEC && !enable_q && cmd_done && !cmd_err
		&& !wr_abort |=> state_q == GEC_IDLE ##1 !fetch_q || en_rise)
		else $error("disabled engine did not stop after command");

endmodule

// [tb_top.sv]
`timescale 1ns/1ps
`include "gec_map.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end

module tb_top
	import gec_pkg::*;
;
	localparam logic [11:0] ctl = `GEC_CTRL_OFF;
	localparam logic [11:0] sts = `GEC_STATUS_OFF;
	logic        mclk;
	logic        rst;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0]  s_axi_wstrb, cmd_err_reason, cmd_err_type;
	logic [1:0]  s_axi_bresp, s_axi_rresp, eb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready, cmd_start, cmd_done, cmd_err;
	logic [15:0] cmd_seq, cmd_value, cmd_value_n, next_sequence_number, v;
	logic        read_master_busy, write_master_busy, fetch_enable, irq;
	logic        engine_abort, engine_restart, flush_pixels, endpoint_stall;
	logic [33:0] er;
	logic [33:0] rq[$];
	logic [1:0]  bq[$];
	int          num_errors, n_checks, n_abort, n_restart;

	gec_ctrl DUT (.mclk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .cmd_start, .cmd_seq, .cmd_value,
		.cmd_value_n, .cmd_done, .cmd_err, .cmd_err_reason, .cmd_err_type,
		.read_master_busy, .write_master_busy, .fetch_enable, .engine_abort,
		.engine_restart, .flush_pixels, .endpoint_stall,
		.next_sequence_number, .irq);

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	task automatic test_done;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = `GEC_RESP_OKAY);
		bq.push_back(r);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wstrb <= 4'hf;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] d,
		input logic [1:0] r = `GEC_RESP_OKAY);
		rq.push_back({r, d});
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask

	// command offer; ok low corrupts the complement copy
	task automatic go(input logic [15:0] s, input logic ok);
		v = 16'($urandom);
		@(posedge mclk);
		cmd_start <= 1'b1;
		cmd_seq <= s;
		cmd_value <= v;
		cmd_value_n <= ok ? ~v : v;
		@(posedge mclk);
		cmd_start <= 1'b0;
	endtask

	task automatic fin(input logic e);
		@(posedge mclk);
		cmd_err <= e;
		cmd_done <= ~e;
		@(posedge mclk);
		cmd_err <= 1'b0;
		cmd_done <= 1'b0;
	endtask

	function automatic logic [31:0] st(input logic [15:0] n,
		input logic [3:0] t, input logic [3:0] e, input logic [1:0] s);
		return {n, 4'h0, t, e, 2'b00, s};
	endfunction

	// result watcher: oldest note against each response
	always @(posedge mclk) begin
		if (s_axi_rvalid && s_axi_rready) begin
			er = rq.pop_front();
			`CHK({s_axi_rresp, s_axi_rdata}, er)
		end
		if (s_axi_bvalid && s_axi_bready) begin
			eb = bq.pop_front();
			`CHK(s_axi_bresp, eb)
		end
		if (engine_abort)
			n_abort++;
		if (engine_restart)
			n_restart++;
		if (engine_restart || flush_pixels)
			`CHK(flush_pixels, engine_restart)
	end

	initial begin
		repeat (6000) @(posedge mclk);
		num_errors++;
		test_done();
	end

	initial begin
		void'($urandom(57));
		rst = 1'b1;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
		{s_axi_arvalid, s_axi_rready, cmd_start, cmd_done, cmd_err} = '0;
		{cmd_seq, cmd_value, cmd_value_n} = '0;
		{read_master_busy, write_master_busy} = '0;
		cmd_err_reason = 4'h4;
		cmd_err_type = 4'h6;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rd(ctl, 32'h0000_0000);
		rd(sts, 32'h0000_0000);
		rd(12'h100, 32'h0000_0000, `GEC_RESP_SLVERR);
		wr(12'h100, 32'hffff_ffff, `GEC_RESP_SLVERR);
		wr(ctl, 32'h1234_ffe9);
		rd(ctl, 32'h1234_0009);
		rd(sts, st(16'h1234, 4'h0, 4'h0, GEC_IDLE));
		@(negedge mclk);
		`CHK(fetch_enable, 1'b1)
		go(16'h1234, 1'b1);
		rd(sts, st(16'h1234, 4'h0, 4'h0, GEC_EXEC));
		fin(1'b0);
		rd(sts, st(16'h1235, 4'h0, 4'h0, GEC_IDLE));
		wr(ctl, 32'h00aa_0019);
		rd(sts, st(16'h1235, 4'h0, 4'h0, GEC_IDLE));
		go(16'h1235, 1'b0);
		rd(sts, st(16'h1235, 4'h0, `GEC_ERR_BAD_COMP, GEC_STALL));
		@(negedge mclk);
		`CHK(endpoint_stall, 1'b1)
		wr(ctl, 32'h00aa_001b);
		rd(sts, st(16'h00aa, 4'h0, 4'h0, GEC_IDLE));
		rd(ctl, 32'h00aa_0019);
		go(16'h0000, 1'b1);
		rd(sts, st(16'h00aa, 4'h0, `GEC_ERR_BAD_SEQ, GEC_STALL));
		wr(ctl, 32'h00aa_001b);
		// both checks off: a bad copy must still start
		wr(ctl, 32'h00aa_0001);
		go(16'h5555, 1'b0);
		rd(sts, st(16'h00aa, 4'h0, 4'h0, GEC_EXEC));
		fin(1'b1);
		rd(sts, st(16'h00aa, 4'h6, 4'h4, GEC_STALL));
		wr(ctl, 32'h00aa_0013);
		rd(sts, st(16'h00aa, 4'h0, 4'h0, GEC_IDLE));
		wr(ctl, 32'h00aa_0015);
		rd(sts, st(16'h00aa, 4'h0, `GEC_ERR_ABORT_IDLE, GEC_STALL));
		@(negedge mclk);
		`CHK(endpoint_stall, 1'b1)
		wr(ctl, 32'h00aa_0013);
		go(16'h00aa, 1'b1);
		wr(ctl, 32'h00aa_0015);
		rd(sts, st(16'h00aa, 4'h0, `GEC_ERR_ABORT_EXEC, GEC_STALL));
		rd(ctl, 32'h00aa_0011);
		wr(ctl, 32'h00aa_0013);
		@(negedge mclk);
		`CHK(endpoint_stall, 1'b0)
		`CHK(n_abort, 2)
		`CHK(n_restart, 5)
		// disable while a command runs: it must still finish
		go(16'h00aa, 1'b1);
		wr(ctl, 32'h00aa_0010);
		rd(sts, st(16'h00aa, 4'h0, 4'h0, GEC_EXEC));
		fin(1'b0);
		go(16'h00ab, 1'b1);
		rd(sts, st(16'h00ab, 4'h0, 4'h0, GEC_IDLE));
		@(negedge mclk);
		`CHK(fetch_enable, 1'b0)
		`CHK(next_sequence_number, 16'h00ab)
		rd(`GEC_IRQ_STAT_OFF, 32'h0000_0007);
		`CHK(irq, 1'b0)
		wr(`GEC_IRQ_MASK_OFF, 32'h0000_0002);
		@(negedge mclk);
		`CHK(irq, 1'b1)
		wr(`GEC_IRQ_STAT_OFF, 32'h0000_0002);
		@(negedge mclk);
		`CHK(irq, 1'b0)
		rd(`GEC_IRQ_STAT_OFF, 32'h0000_0005);
		@(posedge mclk);
		read_master_busy <= 1'b1;
		rd(sts, st(16'h00ab, 4'h0, 4'h0, GEC_IDLE) | 32'h8);
		read_master_busy <= 1'b0;
		// re-enable only once everything reports idle
		rd(sts, st(16'h00ab, 4'h0, 4'h0, GEC_IDLE));
		wr(ctl, 32'h0077_0011);
		rd(sts, st(16'h0077, 4'h0, 4'h0, GEC_IDLE));
		@(negedge mclk);
		`CHK(fetch_enable, 1'b1)
		`CHK(rq.size() + bq.size(), 0)
		test_done();
	end
endmodule
